// ==== lnr_pkg.sv ====
package lnr_pkg;
	// Direct special-register addresses
	localparam logic [7:0] LNR_SFR_CONFIG = 8'hC9;
	localparam logic [7:0] LNR_SFR_WINDOW = 8'hD2;
	localparam logic [7:0] LNR_SFR_POINTER = 8'hD3;
	// Core register indices reached through the window
	localparam logic [7:0] LNR_IDX_PAYLOAD_LAST = 8'h07;
	localparam logic [7:0] LNR_IDX_CONTROL = 8'h08;
	localparam logic [7:0] LNR_IDX_STATUS = 8'h09;
	localparam logic [7:0] LNR_IDX_FAULT = 8'h0A;
	localparam logic [7:0] LNR_IDX_LENGTH = 8'h0B;
	localparam logic [7:0] LNR_IDX_DIVIDER = 8'h0C;
	localparam logic [7:0] LNR_IDX_SCALING = 8'h0D;
	localparam logic [7:0] LNR_IDX_IDENT = 8'h0E;
	// Configuration bit positions and reset value
	localparam int LNR_CFG_ON = 7;
	localparam int LNR_CFG_MASTER = 6;
	localparam int LNR_CFG_AUTO = 5;
	localparam logic [7:0] LNR_CFG_RESET = 8'h60;
	// Control bit positions
	localparam int LNR_CTL_STOP = 7;
	localparam int LNR_CTL_SLEEP = 6;
	localparam int LNR_CTL_DIR = 5;
	localparam int LNR_CTL_ACK = 4;
	localparam int LNR_CTL_CLRIRQ = 3;
	localparam int LNR_CTL_CLRERR = 2;
	localparam int LNR_CTL_WAKE = 1;
	localparam int LNR_CTL_START = 0;
	// Status bit positions
	localparam int LNR_ST_ACTIVE = 7;
	localparam int LNR_ST_IDLE = 6;
	localparam int LNR_ST_ABORT = 5;
	localparam int LNR_ST_DREQ = 4;
	localparam int LNR_ST_IRQ = 3;
	localparam int LNR_ST_ERROR = 2;
	localparam int LNR_ST_WAKEUP = 1;
	localparam int LNR_ST_DONE = 0;
	// Masks of implemented bits, slave-only fault bits and readable control bits
	localparam logic [7:0] LNR_FAULT_MASK = 8'h1F;
	localparam logic [7:0] LNR_FAULT_SLAVE_MASK = 8'h18;
	localparam logic [7:0] LNR_LENGTH_MASK = 8'h8F;
	localparam logic [7:0] LNR_IDENT_MASK = 8'h3F;
	localparam logic [7:0] LNR_CTL_KEEP_MASK = 8'h73;
	// Payload length codes
	localparam logic [3:0] LNR_LEN_MAX = 4'h8;
	localparam logic [3:0] LNR_LEN_FROM_ID = 4'hF;
	// Reset values of divider registers (no documented reset, plain default)
	localparam logic [7:0] LNR_DIV_RESET = 8'hFF;
	localparam logic [7:0] LNR_MUL_RESET = 8'hFF;
	// Bus idle timeout
	localparam longint LNR_IDLE_MS = 4000;
	localparam longint LNR_CLK_HZ = 100000000;
	localparam longint LNR_IDLE_CYC = (LNR_IDLE_MS * LNR_CLK_HZ) / 1000;

	// Events from the frame engine
	typedef struct packed {
		logic frame_start;
		logic frame_done;
		logic break_seen;
		logic break_interrupts;
		logic id_received;
		logic wake_sent;
		logic wake_seen;
		logic bus_busy;
		logic [4:0] faults;
	} lnr_evt_s;

	// Settings steering the frame engine
	typedef struct packed {
		logic enabled;
		logic master;
		logic auto_rate;
		logic direction;
		logic enhanced_sum;
		logic [3:0] byte_count;
		logic [8:0] divider;
		logic [4:0] multiplier;
		logic [1:0] prescaler;
		logic [5:0] ident;
	} lnr_cfg_s;

	typedef enum logic [1:0] {
		LNR_IDLE = 2'b00,
		LNR_BUSY = 2'b01,
		LNR_HALT = 2'b11
	} lnr_state_e;
endpackage : lnr_pkg

// ==== lnr_node.sv ====
`timescale 1ns/1ps
// Behaviour
// RQ1: Eight-bit pointer selects core register.
// RQ2: Window reads/writes the pointed core register.
// RQ3: Config bit 7 enables interface.
// RQ4: Config bit 6 selects master, resets master.
// RQ5: Config bit 5 auto rate, slave only.
// RQ6: Fifteen core registers at 0x00-0x0E.
// RQ7: Slave-only bits work only in slave.
// RQ8: Stop bit halts until next break.
// RQ9: Sleep bit sleeps; clearing wakes node.
// RQ10: Direction bit: transmit or receive payload.
// RQ11: Acknowledge bit written, hardware clears.
// RQ12: Clear bits drop irq or error flags.
// RQ13: Wake bit sends wakeup, self-clears.
// RQ14: Start bit runs frame, clears on end.
// RQ15: Software loads frame before starting.
// RQ16: Activity bit; idle flag after four seconds.
// RQ17: Abort flag on early break or stop.
// RQ18: Done clears at start; wakeup flag.
// RQ19: Four fault flags, two slave only; code implements five (mask 0x1F), two slave only (0x18).
// RQ20: Timeout fault on missing response or ack.
// RQ21: Length bit 7 selects enhanced checksum.
// RQ22: Length code 0-8, reserved, or from identifier.
// RQ23: Divider programmed between 200 and 511.
// RQ24: Multiplier used only in master.
// RQ25: Slave payload access only during request.
// RQ26: Single clock, reset values, unused bits zero.
module lnr_node
	import lnr_pkg::*;
#(
	parameter longint IDLE_CYCLES = LNR_IDLE_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	input wire lnr_evt_s i_evt,
	output lnr_cfg_s o_cfg,
	output logic [63:0] o_payload,
	input wire logic [63:0] i_rx_payload,
	input wire logic i_rx_load,
	output logic o_start_pulse,
	output logic o_wake_pulse,
	output logic o_ack_pulse,
	output logic o_halt,
	output logic o_sleep,
	output logic o_irq
);
	logic [7:0] ptr_ff;
	logic [7:0] cfg_ff;
	logic [7:0] payload_ff [8];
	logic [7:0] ctl_ff;
	logic [7:0] status_ff;
	logic [7:0] fault_ff;
	logic [7:0] length_ff;
	logic [7:0] div_ff;
	logic [7:0] mul_ff;
	logic [7:0] ident_ff;
	logic [31:0] idle_cnt_ff;
	lnr_state_e state_ff;
	logic [7:0] rdata_ff;
	logic is_master;
	logic is_slave;
	logic win_wr;
	logic buf_open;
	logic [7:0] ctl_w;
	logic [4:0] faults_eff;
	logic [3:0] nxt_count;

	assign is_master = cfg_ff[LNR_CFG_MASTER]; // RQ4
	assign is_slave = ~is_master;
	// Window write targets the core register the pointer names
	assign win_wr = i_sfr_wr && (i_sfr_addr == LNR_SFR_WINDOW) && cfg_ff[LNR_CFG_ON]; // RQ2 RQ3
	assign ctl_w = (win_wr && ptr_ff == LNR_IDX_CONTROL) ? i_sfr_wdata : 8'h00;
	// Slave may touch payload and identifier only while a request waits on a quiet bus
	assign buf_open = is_master || (status_ff[LNR_ST_DREQ] && !status_ff[LNR_ST_ACTIVE]); // RQ25
	// Slave-only fault bits are masked in master
	assign faults_eff = i_evt.faults & (is_slave ? 5'h1F : LNR_FAULT_MASK[4:0] & ~LNR_FAULT_SLAVE_MASK[4:0]); // RQ19 RQ7

	// Pointer register
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ptr_ff <= 8'h00;
		end else if (i_sfr_wr && i_sfr_addr == LNR_SFR_POINTER) begin
			ptr_ff <= i_sfr_wdata; // RQ1
		end
	end

	// Direct configuration; low bits not implemented
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cfg_ff <= LNR_CFG_RESET; // RQ26
		end else if (i_sfr_wr && i_sfr_addr == LNR_SFR_CONFIG) begin
			cfg_ff <= i_sfr_wdata & 8'hE0; // RQ3 RQ4 RQ5
		end
	end

	// Payload buffer; received data loads from the frame engine
	for (genvar g = 0; g < 8; g++) begin : g_payload
		always_ff @(posedge i_core_clk or negedge i_nrst) begin
			if (!i_nrst) begin
				payload_ff[g] <= 8'h00;
			end else if (i_rx_load) begin
				payload_ff[g] <= i_rx_payload[g*8 +: 8];
			end else if (win_wr && ptr_ff == 8'(g) && buf_open) begin
				payload_ff[g] <= i_sfr_wdata; // RQ6 RQ25
			end
		end
		assign o_payload[g*8 +: 8] = payload_ff[g];
	end

	// Control: strobes and self-clearing requests
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctl_ff <= 8'h00;
		end else begin
			// Kept bits: sleep and direction; sleep only writable in slave
			if (win_wr && ptr_ff == LNR_IDX_CONTROL) begin
				ctl_ff[LNR_CTL_DIR] <= ctl_w[LNR_CTL_DIR]; // RQ10
				ctl_ff[LNR_CTL_SLEEP] <= ctl_w[LNR_CTL_SLEEP] & is_slave; // RQ9
			end
			// Start held until frame ends or fault
			if (ctl_w[LNR_CTL_START] && is_master && !status_ff[LNR_ST_ERROR]) begin
				ctl_ff[LNR_CTL_START] <= 1'b1; // RQ14
			end else if (i_evt.frame_done || |faults_eff) begin
				ctl_ff[LNR_CTL_START] <= 1'b0; // RQ14
			end
			// Wake request cleared once the wakeup has gone out
			if (ctl_w[LNR_CTL_WAKE] && !status_ff[LNR_ST_ERROR]) begin
				ctl_ff[LNR_CTL_WAKE] <= 1'b1; // RQ13
			end else if (i_evt.wake_sent) begin
				ctl_ff[LNR_CTL_WAKE] <= 1'b0; // RQ13
			end
			// Acknowledge taken by the controller in the next cycle
			ctl_ff[LNR_CTL_ACK] <= ctl_w[LNR_CTL_ACK] & is_slave; // RQ11
		end
	end

	assign o_start_pulse = ctl_ff[LNR_CTL_START] && state_ff == LNR_IDLE;
	assign o_wake_pulse = ctl_ff[LNR_CTL_WAKE];
	assign o_ack_pulse = ctl_ff[LNR_CTL_ACK]; // RQ11
	assign o_sleep = ctl_ff[LNR_CTL_SLEEP]; // RQ9
	assign o_halt = state_ff == LNR_HALT; // RQ8

	// Frame sequencing; halt lasts until the next break
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff <= LNR_IDLE;
		end else if (ctl_w[LNR_CTL_STOP] && is_slave) begin
			state_ff <= LNR_HALT; // RQ8
		end else begin
			case (state_ff)
				LNR_IDLE: begin
					if (i_evt.frame_start || o_start_pulse) begin
						state_ff <= LNR_BUSY;
					end
				end
				LNR_BUSY: begin
					if (i_evt.frame_done || |faults_eff) begin
						state_ff <= LNR_IDLE;
					end
				end
				LNR_HALT: begin
					if (i_evt.break_seen) begin
						state_ff <= LNR_IDLE; // RQ8
					end
				end
				default: begin
					state_ff <= LNR_IDLE;
				end
			endcase
		end
	end

	// Fault flags; a new fault beats a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fault_ff <= 8'h00;
		end else begin
			fault_ff <= ((ctl_w[LNR_CTL_CLRERR] ? 8'h00 : fault_ff) | {3'b000, faults_eff}) & LNR_FAULT_MASK; // RQ12 RQ19 RQ20
		end
	end

	// Bus idle counter; slave only, and not while asleep
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			idle_cnt_ff <= 32'h0;
		end else if (i_evt.bus_busy || !is_slave || o_sleep || !cfg_ff[LNR_CFG_ON]) begin
			idle_cnt_ff <= 32'h0;
		end else if (idle_cnt_ff != 32'(IDLE_CYCLES)) begin
			idle_cnt_ff <= idle_cnt_ff + 32'h1; // RQ16
		end
	end

	// Status flags
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_ff <= 8'h00;
		end else begin
			status_ff[LNR_ST_ACTIVE] <= i_evt.bus_busy; // RQ16
			status_ff[LNR_ST_IDLE] <= is_slave && !o_sleep && idle_cnt_ff == 32'(IDLE_CYCLES); // RQ16
			// Abort set in slave by early break or stop (cleared by them in master), cleared by a clean break
			if ((i_evt.break_seen && i_evt.break_interrupts) || ctl_w[LNR_CTL_STOP]) begin
				status_ff[LNR_ST_ABORT] <= is_slave; // RQ17
			end else if (i_evt.break_seen) begin
				status_ff[LNR_ST_ABORT] <= 1'b0; // RQ17
			end
			if (i_evt.id_received && is_slave) begin
				status_ff[LNR_ST_DREQ] <= 1'b1;
			end else if (ctl_w[LNR_CTL_ACK] || ctl_w[LNR_CTL_STOP]) begin
				status_ff[LNR_ST_DREQ] <= 1'b0; // RQ11
			end
			// Pending interrupt: set wins over the clear strobe
			if (i_evt.frame_done || i_evt.id_received || |faults_eff || i_evt.wake_seen) begin
				status_ff[LNR_ST_IRQ] <= 1'b1;
			end else if (ctl_w[LNR_CTL_CLRIRQ]) begin
				status_ff[LNR_ST_IRQ] <= 1'b0; // RQ12
			end
			if (|faults_eff) begin
				status_ff[LNR_ST_ERROR] <= 1'b1;
			end else if (ctl_w[LNR_CTL_CLRERR]) begin
				status_ff[LNR_ST_ERROR] <= 1'b0; // RQ12
			end
			if (i_evt.wake_seen || ctl_ff[LNR_CTL_WAKE]) begin
				status_ff[LNR_ST_WAKEUP] <= 1'b1; // RQ18
			end else if (i_evt.frame_start) begin
				status_ff[LNR_ST_WAKEUP] <= 1'b0;
			end
			if (i_evt.frame_done || i_evt.wake_seen) begin
				status_ff[LNR_ST_DONE] <= 1'b1; // RQ18
			end else if (i_evt.frame_start || o_start_pulse) begin
				status_ff[LNR_ST_DONE] <= 1'b0; // RQ18
			end
		end
	end

	assign o_irq = status_ff[LNR_ST_IRQ];

	// Length, rate and identifier registers
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			length_ff <= 8'h00;
			div_ff <= LNR_DIV_RESET;
			mul_ff <= LNR_MUL_RESET;
			ident_ff <= 8'h00;
		end else if (win_wr) begin
			case (ptr_ff)
				LNR_IDX_LENGTH: length_ff <= i_sfr_wdata & LNR_LENGTH_MASK; // RQ21 RQ22 RQ26
				LNR_IDX_DIVIDER: div_ff <= i_sfr_wdata; // RQ23
				LNR_IDX_SCALING: mul_ff <= i_sfr_wdata;
				LNR_IDX_IDENT: begin
					if (buf_open) begin
						ident_ff <= i_sfr_wdata & LNR_IDENT_MASK; // RQ25
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Effective byte count; identifier bits 5:4 give 2, 2, 4 or 8
	always_comb begin
		nxt_count = 4'h0;
		if (length_ff[3:0] <= LNR_LEN_MAX) begin
			nxt_count = length_ff[3:0]; // RQ22
		end else if (length_ff[3:0] == LNR_LEN_FROM_ID) begin
			case (ident_ff[5:4])
				2'b10: nxt_count = 4'h4;
				2'b11: nxt_count = 4'h8;
				default: nxt_count = 4'h2;
			endcase
		end
	end

	// Settings presented to the frame engine
	always_comb begin
		o_cfg.enabled = cfg_ff[LNR_CFG_ON]; // RQ3
		o_cfg.master = is_master;
		o_cfg.auto_rate = cfg_ff[LNR_CFG_AUTO] & is_slave; // RQ5
		o_cfg.direction = ctl_ff[LNR_CTL_DIR]; // RQ10
		o_cfg.enhanced_sum = length_ff[7]; // RQ21
		o_cfg.byte_count = nxt_count;
		o_cfg.divider = {mul_ff[0], div_ff};
		o_cfg.multiplier = is_master ? mul_ff[5:1] : 5'h00; // RQ24
		o_cfg.prescaler = mul_ff[7:6];
		o_cfg.ident = ident_ff[5:0];
	end

	// Read data: strobes read zero; locked buffer reads zero in slave
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rdata_ff <= 8'h00;
		end else if (i_sfr_rd) begin
			case (i_sfr_addr)
				LNR_SFR_POINTER: rdata_ff <= ptr_ff;
				LNR_SFR_CONFIG: rdata_ff <= cfg_ff;
				LNR_SFR_WINDOW: begin
					if (ptr_ff <= LNR_IDX_PAYLOAD_LAST) begin
						rdata_ff <= buf_open ? payload_ff[ptr_ff[2:0]] : 8'h00; // RQ2 RQ25
					end else begin
						case (ptr_ff)
							LNR_IDX_CONTROL: rdata_ff <= ctl_ff & LNR_CTL_KEEP_MASK; // RQ8 RQ12
							LNR_IDX_STATUS: rdata_ff <= status_ff;
							LNR_IDX_FAULT: rdata_ff <= fault_ff;
							LNR_IDX_LENGTH: rdata_ff <= length_ff;
							LNR_IDX_DIVIDER: rdata_ff <= div_ff;
							LNR_IDX_SCALING: rdata_ff <= mul_ff;
							LNR_IDX_IDENT: rdata_ff <= buf_open ? ident_ff : 8'h00;
							default: rdata_ff <= 8'h00; // RQ6
						endcase
					end
				end
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	assign o_sfr_rdata = rdata_ff;

	// Checks
	sequence s_stop_write;
		ctl_w[LNR_CTL_STOP] && is_slave;
	endsequence

	chk_stop_halts: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ8
		s_stop_write |=> o_halt && status_ff[LNR_ST_ABORT])
		else $error("stop write did not halt and flag abort");
	chk_halt_holds: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ8
		o_halt && !i_evt.break_seen && !ctl_w[LNR_CTL_STOP] |=> o_halt)
		else $error("halt left without a break");
	chk_ack_self_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ11
		o_ack_pulse && !ctl_w[LNR_CTL_ACK] |=> !o_ack_pulse)
		else $error("acknowledge did not self clear");
	chk_irq_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ12
		ctl_w[LNR_CTL_CLRIRQ] && !i_evt.frame_done && !i_evt.id_received && !(|faults_eff) && !i_evt.wake_seen
		|=> !o_irq)
		else $error("irq flag not cleared");
	chk_err_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ12
		ctl_w[LNR_CTL_CLRERR] && !(|faults_eff) |=> fault_ff == 8'h00 && !status_ff[LNR_ST_ERROR])
		else $error("error flags not cleared");
	chk_start_end: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ14
		ctl_ff[LNR_CTL_START] && i_evt.frame_done && !ctl_w[LNR_CTL_START] |=> !ctl_ff[LNR_CTL_START])
		else $error("start bit not returned on completion");
	chk_done_start: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ18
		o_start_pulse && !i_evt.frame_done && !i_evt.wake_seen |=> !status_ff[LNR_ST_DONE])
		else $error("done not cleared at frame start");
	chk_slave_fault: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ19
		is_master && $stable(is_master) && !$past(fault_ff[4]) && !$past(ctl_w[LNR_CTL_CLRERR]) |-> !fault_ff[4])
		else $error("slave-only fault set in master");
	chk_mult_slave: assert property (@(posedge i_core_clk) disable iff (!i_nrst) // RQ24
		is_slave |-> o_cfg.multiplier == 5'h00 && !o_cfg.auto_rate == !cfg_ff[LNR_CFG_AUTO])
		else $error("multiplier passed in slave");
endmodule : lnr_node

// ==== lnr_bus_model.sv ====
`timescale 1ns/1ps
// Far-side frame engine and bus: answers start and wake requests after fixed delays
module lnr_bus_model
	import lnr_pkg::*;
#(
	parameter int FRAME_CYC = 20
) (
	input wire logic i_clk,
	input wire logic i_start,
	input wire logic i_wake,
	input wire logic i_dir,
	input wire logic i_break,
	input wire logic i_ident,
	input wire logic [4:0] i_fault,
	output lnr_evt_s o_evt,
	output logic [63:0] o_rx_payload,
	output logic o_rx_load
);
	localparam logic [63:0] RX_BYTES = 64'h8877665544332211;
	int cnt = 0;
	int wcnt = 0;

	// Launched just after the rising edge so the node never sees a half-changed event
	always @(posedge i_clk) begin
		o_evt <= '0;
		o_rx_load <= 1'b0;
		o_rx_payload <= ~RX_BYTES; // Released lines do not repeat the last frame
		o_evt.break_seen <= i_break;
		o_evt.id_received <= i_ident;
		o_evt.faults <= i_fault;
		o_evt.bus_busy <= (cnt > 1);
		if (cnt == 0 && i_start === 1'b1) begin
			o_evt.frame_start <= 1'b1;
			cnt <= FRAME_CYC;
		end else if (cnt == 1) begin
			o_evt.frame_done <= 1'b1;
			o_rx_load <= !i_dir;
			o_rx_payload <= RX_BYTES;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
		// Wakeup takes a few cycles on the wire before it counts as sent
		// Request is still up in the cycle the node sees wake_sent; do not restart on it
		if (wcnt == 0 && i_wake === 1'b1 && !o_evt.wake_sent) begin
			wcnt <= 3;
		end else if (wcnt == 1) begin
			o_evt.wake_sent <= 1'b1;
			wcnt <= 0;
		end else if (wcnt > 1) begin
			wcnt <= wcnt - 1;
		end
	end
endmodule : lnr_bus_model

// ==== lnr_node_register_interface_tb.sv ====
`timescale 1ns/1ps
module lnr_node_register_interface_tb;
	import lnr_pkg::*;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, brk = 0, idp = 0;
	logic [7:0] addr = 0, wdata = 0, rdata, v;
	logic [4:0] flt = 0;
	lnr_evt_s evt;
	lnr_cfg_s cfg;
	logic [63:0] payload, rx_payload;
	logic rx_load, start_p, wake_p, ack_p, halt, sleep, irq;
	int n_errors = 0, n_tests = 0, n_starts = 0, n_acks = 0, s0;

	lnr_node #(.IDLE_CYCLES(50)) u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wr(wr),
		.i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_evt(evt), .o_cfg(cfg), .o_payload(payload),
		.i_rx_payload(rx_payload), .i_rx_load(rx_load), .o_start_pulse(start_p), .o_wake_pulse(wake_p),
		.o_ack_pulse(ack_p), .o_halt(halt), .o_sleep(sleep), .o_irq(irq));
	lnr_bus_model u_bus (.i_clk(clk), .i_start(start_p), .i_wake(wake_p), .i_dir(cfg.direction), .i_break(brk),
		.i_ident(idp), .i_fault(flt), .o_evt(evt), .o_rx_payload(rx_payload), .o_rx_load(rx_load));

	initial begin
		forever #5 clk = ~clk;
	end

	// Count cycles with start or ack requests raised
	always @(posedge clk) begin
		if (start_p === 1'b1) n_starts++;
		if (ack_p === 1'b1) n_acks++;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask : sfr_wr

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		@(negedge clk);
		d = rdata;
	endtask : sfr_rd

	task automatic creg_wr(input logic [7:0] idx, input logic [7:0] d);
		sfr_wr(LNR_SFR_POINTER, idx);
		sfr_wr(LNR_SFR_WINDOW, d);
	endtask : creg_wr

	task automatic creg_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] m, input string what);
		sfr_wr(LNR_SFR_POINTER, idx);
		sfr_rd(LNR_SFR_WINDOW, v);
		chk(v & m, exp, what);
	endtask : creg_chk

	task automatic evt_pulse(input logic b, input logic i, input logic [4:0] f);
		@(negedge clk);
		brk = b;
		idp = i;
		flt = f;
		@(negedge clk);
		brk = 0;
		idp = 0;
		flt = 0;
		repeat (3) @(negedge clk);
	endtask : evt_pulse

	task automatic wait_irq();
		for (int k = 0; k < 100 && irq !== 1'b1; k++) @(negedge clk);
		chk({7'h0, irq}, 8'h01, "irq after frame");
	endtask : wait_irq

	task automatic t_reset();
		sfr_rd(LNR_SFR_CONFIG, v);
		chk(v, LNR_CFG_RESET, "config reset");
		sfr_rd(LNR_SFR_POINTER, v);
		chk(v, 8'h00, "pointer reset");
		for (int i = 0; i < 15; i++) creg_chk(i[7:0], (i == 12 || i == 13) ? 8'hFF : 8'h00, 8'hFF, "core reset");
		sfr_wr(LNR_SFR_CONFIG, 8'hFF);
		sfr_rd(LNR_SFR_CONFIG, v);
		chk(v, 8'hE0, "config unused bits");
		chk({7'h0, cfg.auto_rate}, 8'h00, "auto rate in master");
	endtask : t_reset

	task automatic t_window();
		for (int i = 0; i < 8; i++) creg_wr(i[7:0], 8'hA0 + i[7:0]);
		for (int i = 0; i < 8; i++) creg_chk(i[7:0], 8'hA0 + i[7:0], 8'hFF, "payload readback");
		chk(payload[63:56], 8'hA7, "payload out top");
		chk(payload[7:0], 8'hA0, "payload out low");
		sfr_rd(LNR_SFR_POINTER, v);
		chk(v, 8'h07, "pointer readback");
		creg_wr(8'h0F, 8'h55);
		creg_chk(8'h0F, 8'h00, 8'hFF, "beyond last index");
		sfr_rd(8'h80, v);
		chk(v, 8'h00, "unmapped address");
		creg_wr(LNR_IDX_LENGTH, 8'hFF);
		creg_chk(LNR_IDX_LENGTH, 8'h8F, 8'hFF, "length bits");
		creg_wr(LNR_IDX_IDENT, 8'hFF);
		creg_chk(LNR_IDX_IDENT, 8'h3F, 8'hFF, "ident bits");
		chk({4'h0, cfg.byte_count}, 8'h08, "length from ident");
		chk({7'h0, cfg.enhanced_sum}, 8'h01, "enhanced sum");
		creg_wr(LNR_IDX_DIVIDER, 8'hC8);
		creg_wr(LNR_IDX_SCALING, 8'h6B);
		chk(cfg.divider[7:0], 8'hC8, "divider low");
		chk({7'h0, cfg.divider[8]}, 8'h01, "divider top");
		chk({3'h0, cfg.multiplier}, 8'h15, "multiplier in master");
		chk({6'h0, cfg.prescaler}, 8'h01, "prescaler");
		sfr_wr(LNR_SFR_CONFIG, 8'h40);
		creg_wr(8'h00, 8'h12);
		sfr_wr(LNR_SFR_CONFIG, 8'hC0);
		creg_chk(8'h00, 8'hA0, 8'hFF, "write while disabled");
	endtask : t_window

	task automatic t_master();
		creg_wr(LNR_IDX_IDENT, 8'h11);
		creg_wr(LNR_IDX_LENGTH, 8'h08);
		chk({4'h0, cfg.byte_count}, 8'h08, "length code 8");
		chk({7'h0, cfg.enhanced_sum}, 8'h00, "classic sum");
		s0 = n_starts;
		creg_wr(LNR_IDX_CONTROL, 8'h21);
		creg_chk(LNR_IDX_CONTROL, 8'h01, 8'h01, "start held while busy");
		wait_irq();
		chk({7'h0, n_starts != s0}, 8'h01, "start issued");
		creg_chk(LNR_IDX_CONTROL, 8'h20, 8'hFF, "start cleared, dir kept");
		creg_chk(LNR_IDX_STATUS, 8'h09, 8'hFF, "done and irq");
		creg_wr(LNR_IDX_CONTROL, 8'h28);
		creg_chk(LNR_IDX_STATUS, 8'h01, 8'hFF, "irq cleared");
		chk({7'h0, irq}, 8'h00, "irq line low");
		creg_wr(LNR_IDX_CONTROL, 8'h01);
		wait_irq();
		creg_chk(8'h00, 8'h11, 8'hFF, "rx byte 1");
		creg_chk(LNR_IDX_PAYLOAD_LAST, 8'h88, 8'hFF, "rx byte 8");
		creg_wr(LNR_IDX_CONTROL, 8'h08);
	endtask : t_master

	task automatic t_fault();
		evt_pulse(0, 0, 5'h02);
		creg_chk(LNR_IDX_FAULT, 8'h02, 8'hFF, "checksum fault");
		creg_chk(LNR_IDX_STATUS, 8'h04, 8'h04, "error status");
		evt_pulse(0, 0, 5'h10);
		creg_chk(LNR_IDX_FAULT, 8'h02, 8'hFF, "sync fault masked in master");
		s0 = n_starts;
		creg_wr(LNR_IDX_CONTROL, 8'h01);
		repeat (5) @(negedge clk);
		chk({7'h0, n_starts != s0}, 8'h00, "start refused on error");
		creg_wr(LNR_IDX_CONTROL, 8'h0C);
		creg_chk(LNR_IDX_FAULT, 8'h00, 8'hFF, "faults cleared");
		creg_chk(LNR_IDX_STATUS, 8'h00, 8'h0C, "error and irq cleared");
	endtask : t_fault

	task automatic t_wake();
		creg_wr(LNR_IDX_CONTROL, 8'h02);
		chk({7'h0, wake_p}, 8'h01, "wake raised");
		for (int k = 0; k < 50 && wake_p !== 1'b0; k++) @(negedge clk);
		chk({7'h0, wake_p}, 8'h00, "wake dropped");
		creg_chk(LNR_IDX_CONTROL, 8'h00, 8'h02, "wake bit self-cleared");
		creg_wr(LNR_IDX_CONTROL, 8'h0C);
	endtask : t_wake

	task automatic t_slave();
		sfr_wr(LNR_SFR_CONFIG, 8'hA0);
		chk({7'h0, cfg.auto_rate}, 8'h01, "auto rate in slave");
		sfr_wr(LNR_SFR_CONFIG, 8'h80);
		chk({3'h0, cfg.multiplier}, 8'h00, "multiplier ignored in slave");
		creg_wr(8'h00, 8'h5A);
		creg_chk(8'h00, 8'h00, 8'hFF, "payload locked");
		chk(payload[7:0], 8'h11, "locked write ignored");
		evt_pulse(0, 1, 5'h00);
		creg_chk(LNR_IDX_STATUS, 8'h10, 8'h10, "data request");
		creg_wr(8'h00, 8'h5A);
		creg_chk(8'h00, 8'h5A, 8'hFF, "payload open");
		s0 = n_acks;
		creg_wr(LNR_IDX_CONTROL, 8'h10);
		// The acknowledge stands in the cycle after the write; let that edge pass
		@(negedge clk);
		chk({7'h0, n_acks == s0 + 1}, 8'h01, "one ack pulse");
		creg_chk(LNR_IDX_CONTROL, 8'h00, 8'h10, "ack self-cleared");
		creg_chk(LNR_IDX_STATUS, 8'h00, 8'h10, "request cleared");
		creg_wr(LNR_IDX_CONTROL, 8'h80);
		chk({7'h0, halt}, 8'h01, "halted");
		creg_chk(LNR_IDX_CONTROL, 8'h00, 8'h80, "stop reads 0");
		creg_chk(LNR_IDX_STATUS, 8'h20, 8'h20, "abort flag");
		evt_pulse(1, 0, 5'h00);
		chk({7'h0, halt}, 8'h00, "break resumes");
		repeat (60) @(negedge clk);
		creg_chk(LNR_IDX_STATUS, 8'h40, 8'h40, "idle flag");
		creg_wr(LNR_IDX_CONTROL, 8'h40);
		chk({7'h0, sleep}, 8'h01, "sleep on");
		creg_wr(LNR_IDX_CONTROL, 8'h00);
		chk({7'h0, sleep}, 8'h00, "sleep off");
	endtask : t_slave

	task automatic tally_and_finish();
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (8) @(negedge clk);
		nrst = 1;
		t_reset();
		t_window();
		t_master();
		t_fault();
		t_wake();
		t_slave();
		tally_and_finish();
	end

	// Whole run needs under a thousand cycles; this 20000-cycle limit is many times that
	initial begin
		#200000;
		n_errors++;
		$display("FAIL %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : lnr_node_register_interface_tb
